// File: kdr_far_model.sv
`timescale 1ns/1ps
module kdr_far_model
(
  // clock
  input  wire logic       clock,
  // device pins
  input  wire logic [2:0] dma_ack_code,
  input  wire logic       addr_latch,
  input  wire logic       read_strobe,
  input  wire logic       write_strobe,
  input  wire logic       strobe_oe,
  // board side view
  output logic [7:0]      ack_n,
  output logic [7:0]      lat_len,
  output logic [7:0]      rd_len,
  output logic [7:0]      wr_len
);
  // lengths start at zero so that a strobe that never came reads as known
  logic       lat_q = 1'b0;
  logic       rd_q  = 1'b0;
  logic       wr_q  = 1'b0;
  logic [7:0] lat_c = 8'h00;
  logic [7:0] rd_c  = 8'h00;
  logic [7:0] wr_c  = 8'h00;

  // ---------------------------------------------------------------
  // board decoder and external clock chip
  // ---------------------------------------------------------------
  // one-of-eight active-low decode of the acknowledge code
  assign ack_n = ~(8'h01 << dma_ack_code);

  // measured lengths seen by the bench
  assign lat_len = lat_c;
  assign rd_len  = rd_c;
  assign wr_len  = wr_c;

  // the clock chip measures each strobe; a length restarts at every rising edge
  always @(posedge clock)
  begin
    if (addr_latch && strobe_oe)
      lat_c <= lat_q ? lat_c + 8'h01 : 8'h01;
    if (read_strobe && strobe_oe)
      rd_c <= rd_q ? rd_c + 8'h01 : 8'h01;
    if (write_strobe)
      wr_c <= wr_q ? wr_c + 8'h01 : 8'h01;
    lat_q <= addr_latch && strobe_oe;
    rd_q <= read_strobe && strobe_oe;
    wr_q <= write_strobe;
  end
endmodule

// File: kdr_pin_mux.sv
// Overview of operation
// [RULE1] keyboard controller off: acknowledge code pins carry encoded grant; else idle code
// [RULE2] the code shows the channel granted to a dma device or 16-bit master
// [RULE3] board logic decodes the code into active-low acks for channels 7-5, 3-0
// [RULE4] keyboard data pin is keyboard data or channel 3 ack; clock pin or channel 5
// [RULE5] address-20 gate is gate or channel 6 ack; keyboard reset is reset or channel 7
// [RULE6] crystal pin is internal clock timebase, or interrupt request with external clock
// [RULE7] internal clock: power strobe pin sets the clock control register at power-up
// [RULE8] external clock: read strobe makes the clock drive the peripheral data bus
// [RULE9] internal clock: power-good low isolates the clock from the processor
// [RULE10] external clock: address latch pulse latches address from the peripheral bus
// [RULE11] external clock: write strobe makes the clock store peripheral bus data
// [RULE12] mouse clock pin is mouse clock or general purpose bit zero
// [RULE13] keyboard enable and clock select settings are held and steer every pin; the mouse clock pin follows gpio_select instead
`timescale 1ns/1ps
module kdr_pin_mux
  import kdr_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // configuration straps
  input  wire logic              kbc_enable_strap,
  input  wire logic              rtc_internal_strap,
  input  wire logic              gpio_select,
  // dma grant and keyboard controller side
  input  wire kdr_pkg::kdr_grant_s grant,
  input  wire kdr_pkg::kdr_kbd_s   kbd,
  output logic                   kbd_data_in,
  // external clock access request
  input  wire logic              rtc_req,
  input  wire logic              rtc_req_write,
  output logic                   rtc_busy,
  output logic                   rtc_done,
  // internal clock core side
  output logic                   rtc_timebase,
  output logic                   rtc_power_strobe_n,
  output logic                   rtc_isolate,
  output logic                   clock_chip_irq_in,
  // mouse and general purpose side
  input  wire logic              mouse_clock_out,
  input  wire logic              mouse_clock_oe,
  input  wire logic              general_io_bit_zero_out,
  input  wire logic              general_io_bit_zero_oe,
  output logic                   mouse_clock_in,
  output logic                   general_io_bit_zero_in,
  // shared pins
  output logic [2:0]             dma_ack_code,
  input  wire logic              keyboard_data_pin_in,
  output logic                   keyboard_data_pin_out,
  output logic                   keyboard_data_pin_oe,
  output logic                   keyboard_clock_pin,
  output logic                   address_bit20_gate_n,
  output logic                   keyboard_reset_out_n,
  input  wire logic              rtc_crystal_in,
  output logic                   rtc_crystal_out,
  input  wire logic              power_strobe_in,
  output logic                   rtc_read_strobe,
  output logic                   rtc_read_strobe_oe,
  input  wire logic              power_good_in,
  output logic                   rtc_addr_latch,
  output logic                   rtc_addr_latch_oe,
  input  wire logic              mouse_clock_pin_in,
  output logic                   mouse_clock_pin_out,
  output logic                   mouse_clock_pin_oe
);
  import kdr_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_meta_reg;
  logic [SYNC_W-1:0] sync_reg;

  assign sync_raw = {rtc_internal_strap, kbc_enable_strap, mouse_clock_pin_in,
                     power_good_in, power_strobe_in, rtc_crystal_in, keyboard_data_pin_in};

  // two stages for every pin input
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_meta_reg <= '0;
      sync_reg      <= '0;
    end
    else
    begin
      sync_meta_reg <= sync_raw;
      sync_reg      <= sync_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // configuration capture
  // ---------------------------------------------------------------
  logic [1:0] start_cnt_reg;
  logic       cfg_done_reg;
  logic       kbc_en_reg;
  logic       rtc_int_reg;
  logic       cfg_take;

  // straps are taken once the synchroniser has filled after release
  assign cfg_take = !cfg_done_reg && (start_cnt_reg == 2'h2);

  // settings held for the life of the reset
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      start_cnt_reg <= '0;
      cfg_done_reg  <= 1'b0;
      kbc_en_reg    <= KBC_EN_RESET;
      rtc_int_reg   <= RTC_INT_RESET;
    end
    else
    begin
      if (!cfg_done_reg)
        start_cnt_reg <= start_cnt_reg + 2'h1;
      if (cfg_take)
      begin
        cfg_done_reg <= 1'b1;
        kbc_en_reg   <= sync_reg[S_KBC_STR];  // see [RULE13]
        rtc_int_reg  <= sync_reg[S_RTC_STR];  // see [RULE13]
      end
    end
  end

  // ---------------------------------------------------------------
  // dma acknowledge and keyboard pin selection
  // ---------------------------------------------------------------
  logic       dma_mode;
  logic [2:0] ack_code_next;
  logic       ack3_n;
  logic       ack5_n;
  logic       ack6_n;
  logic       ack7_n;

  assign dma_mode      = cfg_done_reg && !kbc_en_reg;
  assign ack_code_next = (dma_mode && grant.valid) ? grant.channel
                                                   : ACK_IDLE_CODE;  // see [RULE1] [RULE2]
  assign ack3_n = !(grant.valid && grant.channel == CH3_CODE);
  assign ack5_n = !(grant.valid && grant.channel == CH5_CODE);
  assign ack6_n = !(grant.valid && grant.channel == CH6_CODE);
  assign ack7_n = !(grant.valid && grant.channel == CH7_CODE);

  // registered keyboard and acknowledge pins
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dma_ack_code          <= ACK_IDLE_CODE;
      keyboard_data_pin_out <= 1'b1;
      keyboard_data_pin_oe  <= 1'b0;
      keyboard_clock_pin    <= 1'b1;
      address_bit20_gate_n  <= 1'b1;
      keyboard_reset_out_n  <= 1'b1;
      kbd_data_in           <= 1'b1;
    end
    else
    begin
      dma_ack_code          <= ack_code_next;                              // see [RULE1]
      keyboard_data_pin_out <= dma_mode ? ack3_n : kbd.data_out;           // see [RULE4]
      keyboard_data_pin_oe  <= dma_mode ? 1'b1 : kbd.data_oe;              // see [RULE4]
      keyboard_clock_pin    <= dma_mode ? ack5_n : kbd.clock_out;          // see [RULE4]
      address_bit20_gate_n  <= dma_mode ? ack6_n : kbd.a20_gate_n;         // see [RULE5]
      keyboard_reset_out_n  <= dma_mode ? ack7_n : kbd.reset_n;            // see [RULE5]
      kbd_data_in           <= dma_mode ? 1'b1 : sync_reg[S_KBD_DATA];
    end
  end

  // ---------------------------------------------------------------
  // external clock access sequencer
  // ---------------------------------------------------------------
  kdr_rtc_state_e   state_reg;
  kdr_rtc_state_e   state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             write_reg;
  logic             ext_mode;
  logic             req_take;

  assign ext_mode = cfg_done_reg && !rtc_int_reg;
  assign req_take = (state_reg == RTC_IDLE) && ext_mode && rtc_req;

  // latch pulse, then one strobe, then a done cycle
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      RTC_IDLE:
        if (req_take)
        begin
          state_next = RTC_ALE;
          cnt_next   = CNT_W'(ALE_CYCLES - 1);
        end
      RTC_ALE:
        if (cnt_reg == '0)
        begin
          state_next = RTC_STROBE;
          cnt_next   = CNT_W'(STROBE_CYCLES - 1);
        end
        else
          cnt_next = cnt_reg - CNT_W'(1);
      RTC_STROBE:
        if (cnt_reg == '0)
          state_next = RTC_DONE;
        else
          cnt_next = cnt_reg - CNT_W'(1);
      RTC_DONE:
        state_next = RTC_IDLE;
      default:
        state_next = RTC_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= RTC_IDLE;
      cnt_reg   <= '0;
      write_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (req_take)
        write_reg <= rtc_req_write;
    end
  end

  // ---------------------------------------------------------------
  // clock pins and mouse pin
  // ---------------------------------------------------------------
  logic ale_next;
  logic rd_next;
  logic wr_next;

  assign ale_next = ext_mode && (state_next == RTC_ALE);                   // see [RULE10]
  assign rd_next  = ext_mode && (state_next == RTC_STROBE) && !write_reg;  // see [RULE8]
  assign wr_next  = ext_mode && (state_next == RTC_STROBE) && write_reg;   // see [RULE11]

  // registered clock-side and mouse-side pins
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rtc_addr_latch      <= 1'b0;
      rtc_addr_latch_oe   <= 1'b0;
      rtc_read_strobe     <= 1'b0;
      rtc_read_strobe_oe  <= 1'b0;
      rtc_crystal_out     <= 1'b0;
      rtc_busy            <= 1'b0;
      rtc_done            <= 1'b0;
      rtc_timebase        <= 1'b0;
      rtc_power_strobe_n  <= 1'b1;
      rtc_isolate         <= 1'b1;
      clock_chip_irq_in   <= 1'b0;
      mouse_clock_pin_out <= 1'b1;
      mouse_clock_pin_oe  <= 1'b0;
      mouse_clock_in      <= 1'b1;
      general_io_bit_zero_in <= 1'b0;
    end
    else
    begin
      rtc_addr_latch      <= ale_next;
      rtc_addr_latch_oe   <= ext_mode;
      rtc_read_strobe     <= rd_next;
      rtc_read_strobe_oe  <= ext_mode;
      rtc_crystal_out     <= wr_next;
      rtc_busy            <= state_next != RTC_IDLE;
      rtc_done            <= state_next == RTC_DONE;
      rtc_timebase        <= rtc_int_reg && sync_reg[S_XTAL];              // see [RULE6]
      clock_chip_irq_in   <= ext_mode && !sync_reg[S_XTAL];                // see [RULE6]
      rtc_power_strobe_n  <= ext_mode || sync_reg[S_PSTROBE];              // see [RULE7]
      rtc_isolate         <= ext_mode || !sync_reg[S_PGOOD];               // see [RULE9]
      mouse_clock_pin_out <= gpio_select ? general_io_bit_zero_out : mouse_clock_out;
      mouse_clock_pin_oe  <= gpio_select ? general_io_bit_zero_oe : mouse_clock_oe; // see [RULE12]
      mouse_clock_in      <= gpio_select ? 1'b1 : sync_reg[S_MOUSE];
      general_io_bit_zero_in <= gpio_select && sync_reg[S_MOUSE];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_ack_code;
    @(posedge clock) disable iff (!reset_n)
    (dma_mode && grant.valid) |=> (dma_ack_code == $past(grant.channel));
  endproperty
  a_ack_code: assert property (p_ack_code) else $error("ack code not the grant"); // see [RULE2]

  property p_ack_idle;
    @(posedge clock) disable iff (!reset_n)
    kbc_en_reg |=> (dma_ack_code == ACK_IDLE_CODE);
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("code not idle"); // see [RULE1]

  property p_kbd_ch3;
    @(posedge clock) disable iff (!reset_n)
    (dma_mode && grant.valid && grant.channel == CH3_CODE)
      |=> (!keyboard_data_pin_out && keyboard_data_pin_oe);
  endproperty
  a_kbd_ch3: assert property (p_kbd_ch3) else $error("no channel 3 ack"); // see [RULE4]

  property p_a20_pass;
    @(posedge clock) disable iff (!reset_n)
    (cfg_done_reg && kbc_en_reg) |=> (address_bit20_gate_n == $past(kbd.a20_gate_n));
  endproperty
  a_a20_pass: assert property (p_a20_pass) else $error("gate not passed"); // see [RULE5]

  property p_read_seq;
    @(posedge clock) disable iff (!reset_n)
    (req_take && !rtc_req_write) |=> rtc_addr_latch[*2] ##1 rtc_read_strobe[*6]
      ##1 (!rtc_read_strobe && rtc_done);
  endproperty
  a_read_seq: assert property (p_read_seq) else $error("read sequence wrong"); // see [RULE8]

  property p_write_seq;
    @(posedge clock) disable iff (!reset_n)
    (req_take && rtc_req_write) |=> ##2 (rtc_crystal_out && !rtc_read_strobe)[*6]
      ##1 !rtc_crystal_out;
  endproperty
  a_write_seq: assert property (p_write_seq) else $error("write sequence wrong"); // see [RULE11]

  property p_ale_single;
    @(posedge clock) disable iff (!reset_n)
    $rose(rtc_addr_latch) |=> rtc_addr_latch ##1 !rtc_addr_latch;
  endproperty
  a_ale_single: assert property (p_ale_single) else $error("latch pulse length"); // see [RULE10]

  property p_int_clock;
    @(posedge clock) disable iff (!reset_n)
    (cfg_done_reg && rtc_int_reg)
      |=> (!rtc_addr_latch_oe && !rtc_read_strobe_oe && !clock_chip_irq_in);
  endproperty
  a_int_clock: assert property (p_int_clock) else $error("clock pins driven"); // see [RULE6]

  property p_isolate;
    @(posedge clock) disable iff (!reset_n)
    (cfg_done_reg && rtc_int_reg && !sync_reg[S_PGOOD]) |=> rtc_isolate;
  endproperty
  a_isolate: assert property (p_isolate) else $error("clock not isolated"); // see [RULE9]

  // only once out of reset: on the release edge the pin flops still sit in reset
  property p_gpio;
    @(posedge clock) disable iff (!reset_n)
    (cfg_done_reg && gpio_select) |=> (mouse_clock_pin_oe == $past(general_io_bit_zero_oe));
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio enable not passed"); // see [RULE12]

endmodule

// File: kdr_pin_mux_bench.sv
`timescale 1ns/1ps
module kdr_pin_mux_bench;
  import kdr_pkg::*;
  logic clock, reset_n, kbc_enable_strap, rtc_internal_strap, gpio_select;
  logic rtc_req, rtc_req_write, mouse_clock_out, mouse_clock_oe;
  logic general_io_bit_zero_out, general_io_bit_zero_oe, rtc_crystal_in;
  logic kd_drv, ps_drv, pg_drv, ms_drv;
  kdr_grant_s grant;
  kdr_kbd_s kbd;
  logic kbd_data_in, rtc_busy, rtc_done, rtc_timebase, rtc_power_strobe_n, rtc_isolate;
  logic clock_chip_irq_in, mouse_clock_in, general_io_bit_zero_in;
  logic [2:0] dma_ack_code;
  logic keyboard_data_pin_out, keyboard_data_pin_oe, keyboard_clock_pin;
  logic address_bit20_gate_n, keyboard_reset_out_n, rtc_crystal_out;
  logic rtc_read_strobe, rtc_read_strobe_oe, rtc_addr_latch, rtc_addr_latch_oe;
  logic mouse_clock_pin_out, mouse_clock_pin_oe;
  logic [7:0] ack_n, lat_len, rd_len, wr_len;
  wire keyboard_data_pin_in, power_strobe_in, power_good_in, mouse_clock_pin_in;
  int err_total;
  int tests_run;

  // ---------------------------------------------------------------
  // wires and instances
  // ---------------------------------------------------------------
  // shared pins show the device drive when enabled, else the board level
  assign keyboard_data_pin_in = keyboard_data_pin_oe ? keyboard_data_pin_out : kd_drv;
  assign power_strobe_in = rtc_read_strobe_oe ? rtc_read_strobe : ps_drv;
  assign power_good_in = rtc_addr_latch_oe ? rtc_addr_latch : pg_drv;
  assign mouse_clock_pin_in = mouse_clock_pin_oe ? mouse_clock_pin_out : ms_drv;

  kdr_pin_mux dut (.clock, .reset_n, .kbc_enable_strap, .rtc_internal_strap, .gpio_select,
    .grant, .kbd, .kbd_data_in, .rtc_req, .rtc_req_write, .rtc_busy, .rtc_done,
    .rtc_timebase, .rtc_power_strobe_n, .rtc_isolate, .clock_chip_irq_in,
    .mouse_clock_out, .mouse_clock_oe, .general_io_bit_zero_out, .general_io_bit_zero_oe,
    .mouse_clock_in, .general_io_bit_zero_in, .dma_ack_code, .keyboard_data_pin_in,
    .keyboard_data_pin_out, .keyboard_data_pin_oe, .keyboard_clock_pin,
    .address_bit20_gate_n, .keyboard_reset_out_n, .rtc_crystal_in, .rtc_crystal_out,
    .power_strobe_in, .rtc_read_strobe, .rtc_read_strobe_oe, .power_good_in,
    .rtc_addr_latch, .rtc_addr_latch_oe, .mouse_clock_pin_in, .mouse_clock_pin_out,
    .mouse_clock_pin_oe);

  kdr_far_model far (.clock, .dma_ack_code, .addr_latch(rtc_addr_latch),
    .read_strobe(rtc_read_strobe), .write_strobe(rtc_crystal_out),
    .strobe_oe(rtc_read_strobe_oe), .ack_n, .lat_len, .rd_len, .wr_len);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // clock and hang guard
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    close_out;
  end

  task automatic close_out;
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // let synchroniser and output stages settle, then sample mid-cycle
  task automatic settle;
    repeat (6) @(posedge clock);
    @(negedge clock);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset(input logic kbc, input logic rint);
    @(posedge clock);
    reset_n <= 1'b0;
    kbc_enable_strap <= kbc;
    rtc_internal_strap <= rint;
    repeat (16) @(posedge clock);
    chk(dma_ack_code, ACK_IDLE_CODE, "reset code");
    chk({rtc_isolate, rtc_busy, rtc_read_strobe_oe}, 8'h04, "reset rtc");
    reset_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask

  task automatic t_kbd;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      kbd <= i ? 5'b01001 : 5'b10110;
      grant <= {1'b1, 1'b0, CH3_CODE};
      settle;
      chk(dma_ack_code, ACK_IDLE_CODE, "code while kbc on");
      chk({keyboard_data_pin_out, keyboard_data_pin_oe, keyboard_clock_pin,
           address_bit20_gate_n, keyboard_reset_out_n}, kbd, "kbd pins");
      chk(kbd_data_in, i ? 1'b0 : 1'b1, "kbd data in");
    end
  endtask

  task automatic t_int_rtc;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      rtc_crystal_in <= i[0];
      ps_drv <= i[0];
      pg_drv <= i[0];
      rtc_req <= 1'b1;
      settle;
      chk(rtc_timebase, i[0], "timebase");
      chk(rtc_power_strobe_n, i[0], "power strobe");
      chk(rtc_isolate, !i[0], "isolate");
      chk({clock_chip_irq_in, rtc_busy, rtc_addr_latch_oe}, 8'h00, "no ext use");
    end
    @(posedge clock);
    rtc_req <= 1'b0;
  endtask

  task automatic t_mouse;
    @(posedge clock);
    gpio_select <= 1'b0;
    ms_drv <= 1'b0;
    settle;
    chk({mouse_clock_in, general_io_bit_zero_in}, 8'h00, "mouse in");
    chk(mouse_clock_pin_oe, 1'b0, "mouse oe");
    @(posedge clock);
    gpio_select <= 1'b1;
    ms_drv <= 1'b1;
    settle;
    chk({mouse_clock_in, general_io_bit_zero_in}, 8'h03, "gpio in");
    @(posedge clock);
    general_io_bit_zero_oe <= 1'b1;
    settle;
    chk({mouse_clock_pin_oe, mouse_clock_pin_out}, 8'h02, "gpio out");
  endtask

  task automatic t_dma;
    kbd <= 5'b00000;
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clock);
      grant <= {1'b1, c[0], c[2:0]};
      settle;
      chk(dma_ack_code, c[2:0], "ack code");
      chk(ack_n, ~(8'h01 << c), "decoded ack");
      chk(keyboard_data_pin_out, c != 3, "ch3");
      chk(keyboard_data_pin_oe, 1'b1, "ch3 oe");
      chk(keyboard_clock_pin, c != 5, "ch5");
      chk(address_bit20_gate_n, c != 6, "ch6");
      chk(keyboard_reset_out_n, c != 7, "ch7");
      chk(kbd_data_in, 1'b1, "kbd in in dma mode");
    end
  endtask

  task automatic access(input logic wr);
    int n;
    logic [7:0] wr_old;
    logic [7:0] rd_old;
    wr_old = wr_len;
    rd_old = rd_len;
    @(posedge clock);
    rtc_req <= 1'b1;
    rtc_req_write <= wr;
    @(posedge clock);
    rtc_req <= 1'b0;
    @(negedge clock);
    n = 0;
    while (n < 40 && rtc_done !== 1'b1)
    begin
      @(posedge clock);
      n++;
      @(negedge clock);
    end
    if (n == 40)
    begin
      err_total++;
      close_out;
    end
    // done shows one edge after the last strobe edge counted from the taking edge
    chk(8'(n), 8'(ALE_CYCLES + STROBE_CYCLES), "done delay");
    chk(lat_len, 8'h02, "latch length");
    if (wr)
    begin
      chk(wr_len, 8'h06, "write strobe length");
      chk(rd_len, rd_old, "no read strobe");
    end
    else
    begin
      chk(rd_len, 8'h06, "read strobe length");
      chk(wr_len, wr_old, "no write strobe");
    end
    @(negedge clock);
    chk(rtc_busy, 1'b0, "busy after done");
  endtask

  task automatic t_ext_rtc;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      rtc_crystal_in <= i[0];
      settle;
      chk(clock_chip_irq_in, !i[0], "irq");
      chk({rtc_timebase, rtc_power_strobe_n, rtc_isolate}, 8'h03, "ext core");
      chk({rtc_read_strobe_oe, rtc_addr_latch_oe}, 8'h03, "strobe oe");
    end
    access(1'b0);
    access(1'b1);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    err_total = 0;
    tests_run = 0;
    reset_n = 1'b0;
    {kbc_enable_strap, rtc_internal_strap, gpio_select, rtc_req, rtc_req_write} = 5'h18;
    {mouse_clock_out, mouse_clock_oe, general_io_bit_zero_out, general_io_bit_zero_oe} = 4'h0;
    {rtc_crystal_in, kd_drv, ps_drv, pg_drv, ms_drv} = 5'h0f;
    grant = 5'h00;
    kbd = 5'h00;
    t_reset(1'b1, 1'b1);
    t_kbd;
    t_int_rtc;
    t_mouse;
    t_reset(1'b0, 1'b0);
    t_dma;
    t_ext_rtc;
    close_out;
  end
endmodule

// File: kdr_pkg.sv
package kdr_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ     = 40;
  localparam int ALE_NS        = 50;   // address latch pulse, least time
  localparam int STROBE_NS     = 150;  // read or write strobe, least time
  localparam int ALE_CYCLES    = (ALE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int STROBE_CYCLES = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int CNT_W         = 4;

  // ---------------------------------------------------------------
  // acknowledge codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] ACK_IDLE_CODE = 3'h4;  // cascade channel, still decoded onto ack_n bit 4 by the board decoder
  localparam logic [2:0] CH3_CODE      = 3'h3;
  localparam logic [2:0] CH5_CODE      = 3'h5;
  localparam logic [2:0] CH6_CODE      = 3'h6;
  localparam logic [2:0] CH7_CODE      = 3'h7;
  localparam logic       KBC_EN_RESET  = 1'b1;
  localparam logic       RTC_INT_RESET = 1'b1;

  // ---------------------------------------------------------------
  // synchroniser lanes
  // ---------------------------------------------------------------
  localparam int SYNC_W     = 7;
  localparam int S_KBD_DATA = 0;
  localparam int S_XTAL     = 1;
  localparam int S_PSTROBE  = 2;
  localparam int S_PGOOD    = 3;
  localparam int S_MOUSE    = 4;
  localparam int S_KBC_STR  = 5;
  localparam int S_RTC_STR  = 6;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       valid;     // a dma channel or 16-bit master holds a grant
    logic       master16;  // grant went to a 16-bit bus master
    logic [2:0] channel;
  } kdr_grant_s;

  typedef struct packed {
    logic data_out;
    logic data_oe;
    logic clock_out;
    logic a20_gate_n;
    logic reset_n;
  } kdr_kbd_s;

  typedef enum logic [1:0] {
    RTC_IDLE,
    RTC_ALE,
    RTC_STROBE,
    RTC_DONE
  } kdr_rtc_state_e;

endpackage
